// ### logic/lpsr_host.sv
// host read controller for a low power asynchronous sram
// assumes the sram pins are wired directly, one clk_sys domain, reads only
//
// How it works
// RULE_01: device senses only on enable assertion or address change while enabled.
// RULE_02: simultaneous triggers merge into one sense activity inside the device.
// RULE_03: device sense circuit runs about 5ns per request.
// RULE_04: address access: change address while enabled, data after addr_to_data_time.
// RULE_05: host spaces successive addresses at least min_read_cycle_time apart.
// RULE_06: enable-controlled read: host keeps address stable for the whole cycle.
// RULE_07: host has address stable at enable assertion, zero setup minimum.
// RULE_08: gate access data after gate_to_data_time, or later earlier limit.
// RULE_09: gate access drives data fetched by an earlier address or enable access.
// RULE_10: enable before address change is address access, else enable-controlled.
// RULE_11: merged trigger window lasts 4-5ns; later activity starts another read.
// RULE_12: no resensing without a new trigger; stale output may remain.
// RULE_13: host keeps skew between switching address and control below 4ns.
// RULE_14: host uses one access style; enable delayed until address settled.
// RULE_15: enabled only with primary_select_n low and secondary_select high.
`timescale 1ns/1ns
module lpsr_host
  import lpsr_pkg::*;
#(
  parameter int unsigned ADDR_W = 19,
  parameter int unsigned DATA_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  // user side
  input wire logic req_valid,
  input wire lpsr_mode_t req_mode,
  input wire logic [ADDR_W-1:0] req_addr,
  output logic req_ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  // sram pins
  output logic [ADDR_W-1:0] mem_addr,
  output logic primary_select_n,
  output logic secondary_select,
  output logic output_gate_n,
  output logic write_strobe_n,
  input wire logic [DATA_W-1:0] data_io_i,
  output logic [DATA_W-1:0] data_io_o,
  output logic data_io_oe
);

  // ==========================================================
  // state
  lpsr_state_t state;
  lpsr_mode_t mode;
  logic [ADDR_W-1:0] lat_addr;
  logic [CNT_W-1:0] since_trig;
  logic [CNT_W-1:0] since_gate;
  logic [CNT_W-1:0] need_trig;
  logic [CNT_W-1:0] need_gate;
  logic [DATA_W-1:0] data_sync;
  logic data_stable;
  logic enabled;
  logic spaced;
  logic trig_now;
  logic gate_now;
  logic ready_to_sample;

  lpsr_sync #(
    .WIDTH(DATA_W)
  ) u_data_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d(data_io_i),
    .q(data_sync),
    .stable(data_stable)
  );

  // ==========================================================
  // decode helpers
  // a device time counts only once the synchroniser has caught up with it
  function automatic logic lpsr_elapsed(input logic [CNT_W-1:0] since, input logic [CNT_W-1:0] need);
    return since >= need + CNT_W'(SYNC_STAGES);
  endfunction

  // the spare mode code runs as a plain address access
  function automatic lpsr_mode_t lpsr_legal_mode(input lpsr_mode_t m);
    return (m == LPSR_MODE_ENABLE || m == LPSR_MODE_GATE) ? m : LPSR_MODE_ADDR;
  endfunction

  // ==========================================================
  // decode of our own pin drive
  assign enabled = ~primary_select_n & secondary_select; // RULE_15
  assign spaced = (since_trig >= CNT_W'(CYC_MIN_READ_CYCLE)); // RULE_05
  // one address change is one trigger; the device merges what lands together
  assign trig_now = (state == LPSR_S_ENABLE) ||
                    (state == LPSR_S_LAUNCH && mode == LPSR_MODE_ADDR && enabled && spaced); // RULE_01
  assign gate_now = (state == LPSR_S_LAUNCH) && (mode == LPSR_MODE_GATE) && enabled && output_gate_n;
  // synchroniser latency is added on top of the device times
  assign ready_to_sample = lpsr_elapsed(since_trig, need_trig) &&
                           lpsr_elapsed(since_gate, need_gate) && data_stable; // RULE_08

  // ==========================================================
  // elapsed time since the last read trigger and the last gate assertion of a gate access
  // counters saturate, so a long idle never wraps into an early sample
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      since_trig <= CNT_MAX;
    end else if (trig_now) begin
      since_trig <= '0;
    end else if (since_trig != CNT_MAX) begin
      since_trig <= since_trig + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      since_gate <= CNT_MAX;
    end else if (gate_now) begin
      since_gate <= '0;
    end else if (since_gate != CNT_MAX) begin
      since_gate <= since_gate + 1'b1;
    end
  end

  // ==========================================================
  // access sequencer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= LPSR_S_IDLE;
      mode <= LPSR_MODE_ADDR;
      lat_addr <= '0;
      need_trig <= '0;
      need_gate <= '0;
      req_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      mem_addr <= '0;
      primary_select_n <= 1'b1;
      secondary_select <= 1'b0;
      output_gate_n <= 1'b1;
    end else begin
      rd_valid <= 1'b0;
      unique case (state)
        LPSR_S_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            // a spare code never reaches the sequencer
            mode <= lpsr_legal_mode(req_mode);
            lat_addr <= req_addr;
            state <= LPSR_S_LAUNCH;
          end
        end
        LPSR_S_LAUNCH: begin
          if (!enabled) begin
            // address first, enable on a later edge: a clean enable access
            mem_addr <= lat_addr; // RULE_14
            output_gate_n <= 1'b0;
            need_gate <= '0;
            state <= LPSR_S_ENABLE; // RULE_07
          end else begin
            unique case (mode)
              LPSR_MODE_ADDR: begin
                if (spaced) begin
                  mem_addr <= lat_addr; // RULE_04
                  output_gate_n <= 1'b0;
                  need_trig <= CNT_W'(CYC_ADDR_TO_DATA);
                  need_gate <= '0;
                  state <= LPSR_S_WAIT; // RULE_10
                end
              end
              LPSR_MODE_ENABLE: begin
                // deselect for two cycles so the next assertion is the trigger
                primary_select_n <= 1'b1; // RULE_06
                secondary_select <= 1'b0;
              end
              default: begin
                // gate access: address is left untouched, data was fetched before
                if (output_gate_n) begin
                  output_gate_n <= 1'b0; // RULE_09
                  need_gate <= CNT_W'(CYC_GATE_TO_DATA);
                  state <= LPSR_S_WAIT;
                end else begin
                  output_gate_n <= 1'b1;
                end
              end
            endcase
          end
        end
        LPSR_S_ENABLE: begin
          // both selects move on one edge, so their skew is zero
          // selects stay on after a read, so an address read needs no enable edge
          primary_select_n <= 1'b0; // RULE_13
          secondary_select <= 1'b1; // RULE_15
          need_trig <= CNT_W'(CYC_ENABLE_TO_DATA);
          state <= LPSR_S_WAIT;
        end
        LPSR_S_WAIT: begin
          // address and controls hold still here; an address change or enable assertion would resense
          // limitation: a word sensed wrong stays wrong until a new trigger
          if (ready_to_sample) begin // RULE_11
            rd_data <= data_sync; // RULE_12
            rd_valid <= 1'b1;
            state <= LPSR_S_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // read only host: never writes, never drives the data bus
  // tying the bus off keeps a stray write or bus fight impossible
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      write_strobe_n <= 1'b1;
      data_io_o <= '0;
      data_io_oe <= 1'b0;
    end else begin
      write_strobe_n <= 1'b1; // RULE_04
      data_io_o <= '0;
      data_io_oe <= 1'b0;
    end
  end

endmodule

// ### logic/lpsr_pkg.sv
// package for the low power sram read host: timing figures, cycle counts, modes
// assumes a single 100 mhz system clock
package lpsr_pkg;

  // ==========================================================
  // clock
  localparam int unsigned CLK_PERIOD_NS = 10;

  // ==========================================================
  // device timing figures in ns (plain defaults, set per part)
  localparam int unsigned ADDR_TO_DATA_TIME_NS = 20;
  localparam int unsigned ENABLE_TO_DATA_TIME_NS = 20;
  localparam int unsigned GATE_TO_DATA_TIME_NS = 10;
  localparam int unsigned MIN_READ_CYCLE_TIME_NS = 20;
  localparam int unsigned ADDR_SETUP_TIME_NS = 0;

  // least times round up, never below one cycle
  function automatic int unsigned lpsr_ceil_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned CYC_ADDR_TO_DATA = lpsr_ceil_cycles(ADDR_TO_DATA_TIME_NS);
  localparam int unsigned CYC_ENABLE_TO_DATA = lpsr_ceil_cycles(ENABLE_TO_DATA_TIME_NS);
  localparam int unsigned CYC_GATE_TO_DATA = lpsr_ceil_cycles(GATE_TO_DATA_TIME_NS);
  localparam int unsigned CYC_MIN_READ_CYCLE = lpsr_ceil_cycles(MIN_READ_CYCLE_TIME_NS);
  localparam int unsigned CYC_ADDR_SETUP = lpsr_ceil_cycles(ADDR_SETUP_TIME_NS);

  // latency of the data input synchroniser
  localparam int unsigned SYNC_STAGES = 3;

  // ==========================================================
  // widths and reset values
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

  // ==========================================================
  // read access styles and sequencer states
  typedef enum logic [1:0] {
    LPSR_MODE_ADDR = 2'b00,
    LPSR_MODE_ENABLE = 2'b01,
    LPSR_MODE_GATE = 2'b10
  } lpsr_mode_t;

  typedef enum logic [1:0] {
    LPSR_S_IDLE = 2'b00,
    LPSR_S_LAUNCH = 2'b01,
    LPSR_S_ENABLE = 2'b10,
    LPSR_S_WAIT = 2'b11
  } lpsr_state_t;

endpackage

// ### logic/lpsr_sync.sv
// three-stage synchroniser with agreement flag for asynchronous pin inputs
// assumes the input is sampled on clk_sys and changes freely
`timescale 1ns/1ns
module lpsr_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q,
  output logic stable
);

  // ==========================================================
  // stages; the first is read only by the second
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1 <= '0;
      s2 <= '0;
      q <= '0;
      stable <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      q <= s2;
      stable <= (s2 == q);
    end
  end

endmodule

// ### sim/lpsr_host_props.sv
// checker on the pins of the sram read host
// assumes bind into lpsr_host, one clock domain
`timescale 1ns/1ns
module lpsr_host_props #(
  parameter int unsigned ADDR_W = 19
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rd_valid,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic primary_select_n,
  input wire logic secondary_select,
  input wire logic output_gate_n,
  input wire logic write_strobe_n
);
  // ==========================================
  // pin order
  logic en;
  assign en = !primary_select_n && secondary_select;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  addr_gap_a:
    assert property ($changed(mem_addr) |=> $stable(mem_addr)) else $error("address spacing short");
  en_setup_a:
    assert property ($rose(en) |-> $stable(mem_addr) && !output_gate_n) else $error("enable with moving address");
  addr_hold_a:
    assert property ($rose(en) |=> $stable(mem_addr) [*4]) else $error("address moved in enable read");
  no_write_a:
    assert property (write_strobe_n) else $error("write strobe asserted");
  data_wait_a:
    assert property (rd_valid |-> en && mem_addr == $past(mem_addr, 4) && $past(output_gate_n, 3) == 1'b0)
      else $error("read taken too early");
  ready_back_a:
    assert property (rd_valid |=> req_ready && !rd_valid) else $error("ready not back after read");
  take_drop_a:
    assert property (req_valid && req_ready |=> !req_ready) else $error("ready held after take");
  gate_fresh_a:
    assert property ($rose(output_gate_n) && en |=> $fell(output_gate_n)) else $error("gate not lowered again");
endmodule

// ### sim/lpsr_sram_model.sv
// device model: senses on enable or address change, drives the read word
// assumes the host never writes; slow picks full device times
`timescale 1ns/1ns
module lpsr_sram_model
  import lpsr_pkg::*;
(
  input wire logic slow,
  input wire logic [18:0] mem_addr,
  input wire logic primary_select_n,
  input wire logic secondary_select,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  output logic [7:0] data_io_i
);
  // ==========================================
  // trigger and sense
  logic en;
  logic [7:0] sensed = 8'h00;
  time t_rdy = 0;
  time t_gate = 0;
  assign en = !primary_select_n && secondary_select;
  // one sense per time step, so coincident triggers merge
  always @(posedge en) begin
    sensed = mem_addr[7:0] ^ 8'h5a;
    t_rdy = $time + (slow ? ENABLE_TO_DATA_TIME_NS : ENABLE_TO_DATA_TIME_NS / 2);
  end
  always @(mem_addr) begin
    if (en) begin
      sensed = mem_addr[7:0] ^ 8'h5a;
      t_rdy = $time + (slow ? ADDR_TO_DATA_TIME_NS : ADDR_TO_DATA_TIME_NS / 2);
    end
  end
  always @(negedge output_gate_n) t_gate = $time + GATE_TO_DATA_TIME_NS;
  // released bus moves every cycle, never keeps the last word
  initial data_io_i = 8'h00;
  always #10 begin
    if (en && !output_gate_n && write_strobe_n && $time >= t_rdy && $time >= t_gate)
      data_io_i = sensed;
    else
      data_io_i = ~data_io_i;
  end
endmodule

// ### sim/low_power_sram_read_trigger_bench.sv
// bench for the sram read host: reads in all modes against the device model
// assumes the model answers within the package device times
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module low_power_sram_read_trigger_bench import lpsr_pkg::*;;
  logic clk_sys, reset, req_valid, req_ready, rd_valid, slow;
  logic primary_select_n, secondary_select, output_gate_n, write_strobe_n, data_io_oe;
  lpsr_mode_t req_mode;
  logic [18:0] req_addr, mem_addr;
  logic [7:0] rd_data, data_io_i, data_io_o, exp_now;
  logic [7:0] exp_q[$];
  int failures = 0;
  int compares = 0;
  lpsr_host lpsr_host_inst(.clk_sys, .reset, .req_valid, .req_mode, .req_addr, .req_ready, .rd_valid, .rd_data,
    .mem_addr, .primary_select_n, .secondary_select, .output_gate_n, .write_strobe_n, .data_io_i, .data_io_o,
    .data_io_oe);
  lpsr_sram_model lpsr_sram_model_inst(.slow, .mem_addr, .primary_select_n, .secondary_select, .output_gate_n,
    .write_strobe_n, .data_io_i);
  // ==========================================
  // clock, watchdog, result watcher
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      exp_now = exp_q.size() ? exp_q.pop_front() : 8'hxx;
      `CHK(rd_data, exp_now)
      `CHK(data_io_oe, 1'b0)
    end
  end
  // ==========================================
  // tasks
  task automatic end_sim();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset();
    reset = 1;
    repeat (6) @(negedge clk_sys);
    reset = 0;
    @(negedge clk_sys);
    `CHK({req_ready, primary_select_n, secondary_select, output_gate_n, write_strobe_n, data_io_oe, data_io_o}, 14'h3600)
  endtask
  task automatic rd(input lpsr_mode_t m, input logic [18:0] a);
    int n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    req_valid = 1;
    req_mode = m;
    req_addr = a;
    exp_q.push_back(a[7:0] ^ 8'h5a);
    @(negedge clk_sys);
    req_valid = 0;
    @(negedge clk_sys);
  endtask
  task automatic drain(input int t);
    int n = 0;
    while (exp_q.size() > 0 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(exp_q.size(), 0)
    $display("test %0d done", t);
  endtask
  // ==========================================
  // tests
  initial begin
    lpsr_mode_t m;
    logic [18:0] a;
    reset = 1;
    req_valid = 0;
    req_mode = LPSR_MODE_ADDR;
    req_addr = 19'h00000;
    slow = 0;
    a = 19'h00123;
    void'($urandom(87));
    do_reset();
    // started deselected, so it becomes an enable read
    rd(LPSR_MODE_GATE, a);
    drain(1);
    for (int k = 0; k < 15; k++) begin
      slow = k[0];
      m = lpsr_mode_t'(k % 3);
      // gate reads reuse the fetched word; others always move the address
      if (m != LPSR_MODE_GATE)
        a = a + 19'($urandom_range(1, 4095));
      rd(m, a);
    end
    drain(2);
    // reset in mid-read drops the pending word
    rd(LPSR_MODE_ADDR, a + 19'h00001);
    do_reset();
    exp_q.delete();
    rd(LPSR_MODE_ENABLE, a + 19'h00002);
    rd(lpsr_mode_t'(2'h3), a + 19'h00003);
    drain(3);
    end_sim();
  end
endmodule
bind lpsr_host lpsr_host_props #(.ADDR_W(ADDR_W)) lpsr_host_props_inst(.clk_sys, .reset, .req_valid, .req_ready,
  .rd_valid, .mem_addr, .primary_select_n, .secondary_select, .output_gate_n, .write_strobe_n);
